// ==== brps_pkg.sv ====
package brps_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W      = 24;           // parallel rom address width
	localparam int BYTE_W      = 8;            // shared bus width
	localparam int ADDR_BYTES  = 3;            // address bytes shifted out
	localparam int TIME_W      = 4;            // width of the timing settings

	// ==========================================================
	// shared bus bit positions for the serial rom
	localparam int SR_DIN_BIT  = 2;            // data from the serial rom
	localparam int SR_DOUT_BIT = 1;            // data to the serial rom
	localparam int SR_CLK_BIT  = 0;            // serial clock out

	// ==========================================================
	// timing counts
	localparam logic [3:0] SR_HALF_CYCLES = 4'h4; // serial clock half period in sys clocks
	localparam logic [1:0] PRELOAD_KEY    = 2'h2; // preload enable pattern 10b
	localparam int         SR_ADDR_BITS   = 8;    // serial read address bits
	localparam int         SR_OP_BITS     = 3;    // serial read opcode bits
	localparam logic [2:0] SR_READ_OP     = 3'h6; // serial read opcode 110b

	// ==========================================================
	// reset values
	localparam logic [BYTE_W-1:0] BUS_RESET = 8'h00; // shared bus output at reset

	// ==========================================================
	// parallel access request
	typedef struct packed {
		logic              write;       // 1 write, 0 read
		logic [ADDR_W-1:0] addr;        // byte address
		logic [BYTE_W-1:0] wdata;       // write byte
	} brps_req_s;

	// parallel access timing settings
	typedef struct packed {
		logic              multiDev;    // 1 multiple device mode (select pin is ready input)
		logic [TIME_W-1:0] accessTime;  // chip select length in latch clock periods
		logic [TIME_W-1:0] readMask;    // read strobe lead-in after select
		logic [TIME_W-1:0] writeMask;   // write strobe lead-in after select
	} brps_cfg_s;

	// shared bus pin group
	typedef struct packed {
		logic [BYTE_W-1:0] out;
		logic [BYTE_W-1:0] oe;
	} brps_bus_s;

endpackage : brps_pkg

// ==== brps_serial.sv ====
`timescale 1ns/1ps
`default_nettype none
module brps_serial (
	input  wire logic        clk_sys,     // system clock
	input  wire logic        rst_b,       // async reset, active low
	input  wire logic        start,       // one-cycle pulse: begin preload read
	input  wire logic        dataIn,      // synchronised serial data from rom
	output logic             romSelect,   // serial rom select, active high
	output logic             romClock,    // serial clock
	output logic             romDataOut,  // serial data to rom
	output logic             busy,        // preload in progress
	output logic             done,        // one-cycle pulse at end
	output logic             keyOk,       // preload pattern seen
	output logic [7:0]       firstByte    // first byte read after the key
);

	// ==========================================================
	// state
	typedef enum logic [2:0] {S_IDLE, S_CMD, S_KEY, S_DATA, S_END} brps_ser_e;
	brps_ser_e   state_q, state_d;
	logic [3:0]  div_q, div_d;               // half period divider
	logic        clk_q, clk_d;
	logic [4:0]  cnt_q, cnt_d;               // bit counter
	logic [10:0] shOut_q, shOut_d;           // opcode plus address
	logic [7:0]  shIn_q, shIn_d;
	logic        key_q, key_d;
	logic        done_q, done_d;
	logic        rise;                       // serial clock rising this cycle
	logic        fall;

	assign romSelect  = (state_q != S_IDLE) && (state_q != S_END); // [R14]
	assign romClock   = clk_q;
	assign romDataOut = shOut_q[10];
	assign busy       = state_q != S_IDLE;
	assign done       = done_q;
	assign keyOk      = key_q;
	assign firstByte  = shIn_q;

	// ==========================================================
	// next state: clock divider, shift out command, sample on rising edge
	always_comb begin
		state_d = state_q;
		div_d   = div_q;
		clk_d   = clk_q;
		cnt_d   = cnt_q;
		shOut_d = shOut_q;
		shIn_d  = shIn_q;
		key_d   = key_q;
		done_d  = 1'b0;
		rise    = 1'b0;
		fall    = 1'b0;
		if (state_q inside {S_CMD, S_KEY, S_DATA}) begin
			if (div_q == brps_pkg::SR_HALF_CYCLES - 4'h1) begin
				div_d = 4'h0;
				clk_d = ~clk_q;
				rise  = ~clk_q;
				fall  = clk_q;
			end else begin
				div_d = div_q + 4'h1;
			end
		end
		case (state_q)
			S_IDLE: begin
				if (start) begin
					state_d = S_CMD;
					shOut_d = {brps_pkg::SR_READ_OP, 8'h00};
					cnt_d   = 5'(brps_pkg::SR_OP_BITS + brps_pkg::SR_ADDR_BITS);
					key_d   = 1'b0;
				end
			end
			S_CMD: begin
				// data changes on the falling edge so it is stable at the rising one
				if (fall) begin
					shOut_d = {shOut_q[9:0], 1'b0};
					cnt_d   = cnt_q - 5'h1;
					if (cnt_q == 5'h1) begin
						state_d = S_KEY;
						cnt_d   = 5'h2;
					end
				end
			end
			S_KEY: begin
				if (rise) begin
					shIn_d = {shIn_q[6:0], dataIn};
					cnt_d  = cnt_q - 5'h1;
					// first bit must be 1, or the load stops right after it
					if (cnt_q == 5'h2 && dataIn != brps_pkg::PRELOAD_KEY[1]) begin
						state_d = S_END;                     // [R16]
					end else if (cnt_q == 5'h1) begin
						if ({shIn_q[0], dataIn} == brps_pkg::PRELOAD_KEY) begin
							state_d = S_DATA;
							key_d   = 1'b1;
							cnt_d   = 5'h8;
						end else begin
							state_d = S_END;                 // [R16]
						end
					end
				end
			end
			S_DATA: begin
				if (rise) begin
					shIn_d = {shIn_q[6:0], dataIn};
					cnt_d  = cnt_q - 5'h1;
					if (cnt_q == 5'h1) begin
						state_d = S_END;
					end
				end
			end
			S_END: begin
				state_d = S_IDLE;
				clk_d   = 1'b0;
				div_d   = 4'h0;
				done_d  = 1'b1;
				if (!key_q) begin
					shIn_d = 8'h00;                         // [R16]
				end
			end
			default: state_d = S_IDLE;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= S_IDLE;
			div_q   <= 4'h0;
			clk_q   <= 1'b0;
			cnt_q   <= 5'h0;
			shOut_q <= 11'h000;
			shIn_q  <= 8'h00;
			key_q   <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q   <= div_d;
			clk_q   <= clk_d;
			cnt_q   <= cnt_d;
			shOut_q <= shOut_d;
			shIn_q  <= shIn_d;
			key_q   <= key_d;
			done_q  <= done_d;
		end
	end

endmodule : brps_serial
`default_nettype wire

// ==== brps_sequencer.sv ====
// Functional notes
// [R1] latch enable low across all three address bytes
// [R2] external registers shift while latch enable low
// [R3] external decode enables chips when latch high
// [R4] latch clock is system clock divided two
// [R5] single mode: select low after address out
// [R6] select length set by access time
// [R7] multiple mode: select pin becomes ready input
// [R8] ready low stretches active strobe
// [R9] rom drives read data under read strobe
// [R10] read data captured at strobe rising edge
// [R11] read strobe placed by read mask
// [R12] write data held until strobe rises
// [R13] write strobe placed by write mask
// [R14] serial select high during serial access
// [R15] bus bits two one zero: serial pins
// [R16] missing 10b key ends preload, keeps reset
// [R17] mode setting picks single or multiple
`timescale 1ns/1ps
`default_nettype none
module brps_sequencer (
	input  wire logic                clk_sys,                  // system clock, 200 MHz
	input  wire logic                rst_b,                    // async reset, active low
	input  wire brps_pkg::brps_cfg_s cfg,                      // timing and mode settings
	input  wire logic                reqValid,                 // parallel access request
	input  wire brps_pkg::brps_req_s req,                      // request contents
	output logic                     reqReady,                 // request accepted this cycle
	output logic                     rspValid,                 // one-cycle pulse: access finished
	output logic [7:0]               rspData,                  // read byte
	input  wire logic                preloadStart,             // one-cycle pulse: serial preload
	output logic                     preloadBusy,              // serial preload in progress
	output logic                     preloadDone,              // one-cycle pulse: preload ended
	output logic                     preloadKeyOk,             // key 10b seen
	output logic [7:0]               preloadByte,              // first preload byte
	input  wire logic [7:0]          rom_shared_bus_in,        // shared bus pin level
	output brps_pkg::brps_bus_s      rom_shared_bus,           // shared bus drive and enable
	output logic                     rom_addr_latch_enable_n,  // address latch enable, low active
	output logic                     rom_latch_clock_out,      // latch clock
	output logic                     rom_select_n_out,         // select pin drive, low active
	output logic                     rom_select_n_oe,          // select pin enable
	input  wire logic                rom_device_ready_n,       // select pin level as ready, low active
	output logic                     rom_read_strobe_n,        // read strobe, low active
	output logic                     rom_write_strobe_n,       // write strobe, low active
	output logic                     serial_rom_select         // serial rom select, high active
);

	// ==========================================================
	// pin synchronisers
	logic [7:0] busMeta_q, busSync_q;                         // shared bus input
	logic       rdyMeta_q, rdySync_q;                         // ready input

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			busMeta_q <= 8'h00;
			busSync_q <= 8'h00;
			rdyMeta_q <= 1'b1;
			rdySync_q <= 1'b1;
		end else begin
			busMeta_q <= rom_shared_bus_in;
			busSync_q <= busMeta_q;
			rdyMeta_q <= rom_device_ready_n;
			rdySync_q <= rdyMeta_q;
		end
	end

	// ==========================================================
	// latch clock divider: phase toggles each cycle, work happens on the high phase
	logic phase_q;
	logic phaseTick;                                          // one pulse per latch clock period

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= ~phase_q;                              // [R4]
		end
	end
	assign phaseTick           = phase_q;
	assign rom_latch_clock_out = phase_q;                     // [R4]

	// ==========================================================
	// serial preload engine
	logic srClock, srDataOut;

	brps_serial u_serial (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.start      (preloadStart),
		.dataIn     (busSync_q[brps_pkg::SR_DIN_BIT]),
		.romSelect  (serial_rom_select),
		.romClock   (srClock),
		.romDataOut (srDataOut),
		.busy       (preloadBusy),
		.done       (preloadDone),
		.keyOk      (preloadKeyOk),
		.firstByte  (preloadByte)
	);

	// ==========================================================
	// parallel access state
	typedef enum logic [2:0] {P_IDLE, P_ADDR, P_LEAD, P_STROBE, P_HOLD, P_DONE} brps_par_e;
	brps_par_e         pst_q, pst_d;
	brps_pkg::brps_req_s cur_q, cur_d;
	logic [1:0]        byteCnt_q, byteCnt_d;                  // address byte index
	logic [3:0]        tmr_q, tmr_d;                          // lead-in and access timer
	logic [7:0]        data_q, data_d;                        // captured read byte
	logic              rsp_q, rsp_d;

	// pick one address byte, most significant first
	function automatic logic [7:0] addrByte(input logic [23:0] a, input logic [1:0] idx);
		case (idx)
			2'h0:    addrByte = a[23:16];
			2'h1:    addrByte = a[15:8];
			default: addrByte = a[7:0];
		endcase
	endfunction : addrByte

	// the serial engine owns the bus while busy, so parallel accesses wait
	assign reqReady = (pst_q == P_IDLE) && !preloadBusy;

	// ==========================================================
	// next state for the parallel sequence, advanced on latch clock ticks
	always_comb begin
		pst_d     = pst_q;
		cur_d     = cur_q;
		byteCnt_d = byteCnt_q;
		tmr_d     = tmr_q;
		data_d    = data_q;
		rsp_d     = 1'b0;
		case (pst_q)
			P_IDLE: begin
				if (reqValid && reqReady) begin
					cur_d     = req;
					byteCnt_d = 2'h0;
					pst_d     = P_ADDR;
				end
			end
			P_ADDR: begin
				if (phaseTick) begin
					if (byteCnt_q == 2'(brps_pkg::ADDR_BYTES - 1)) begin
						pst_d = P_LEAD;                       // [R5]
						tmr_d = cur_q.write ? cfg.writeMask : cfg.readMask; // [R11] [R13]
					end else begin
						byteCnt_d = byteCnt_q + 2'h1;         // [R1]
					end
				end
			end
			P_LEAD: begin
				if (phaseTick) begin
					if (tmr_q == 4'h0) begin
						pst_d = P_STROBE;
						tmr_d = cfg.accessTime;               // [R6]
					end else begin
						tmr_d = tmr_q - 4'h1;
					end
				end
			end
			P_STROBE: begin
				// ready low in multiple mode freezes the timer, stretching the strobe
				if (phaseTick && !(cfg.multiDev && !rdySync_q)) begin // [R8] [R17]
					if (tmr_q == 4'h0) begin
						pst_d = P_HOLD;
					end else begin
						tmr_d = tmr_q - 4'h1;
					end
				end
			end
			P_HOLD: begin
				// strobe is already high; data still driven for write hold
				if (phaseTick) begin
					pst_d = P_DONE;
					// the two-flop sync still shows the byte of the last strobe-low cycle
					if (!cur_q.write) begin
						data_d = busSync_q;                   // [R10]
					end
				end
			end
			P_DONE: begin
				rsp_d = 1'b1;
				pst_d = P_IDLE;
			end
			default: pst_d = P_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pst_q     <= P_IDLE;
			cur_q     <= '0;
			byteCnt_q <= 2'h0;
			tmr_q     <= 4'h0;
			data_q    <= 8'h00;
			rsp_q     <= 1'b0;
		end else begin
			pst_q     <= pst_d;
			cur_q     <= cur_d;
			byteCnt_q <= byteCnt_d;
			tmr_q     <= tmr_d;
			data_q    <= data_d;
			rsp_q     <= rsp_d;
		end
	end

	assign rspValid = rsp_q;
	assign rspData  = data_q;

	// ==========================================================
	// pin outputs, registered so they change cleanly
	logic                latchN_q, selN_q, rdN_q, wrN_q;
	brps_pkg::brps_bus_s bus_q, bus_d;
	logic                inAccess;

	// bus follows the next state so it lines up with the registered strobes
	assign inAccess = (pst_d == P_LEAD) || (pst_d == P_STROBE);

	always_comb begin
		bus_d.out = brps_pkg::BUS_RESET;
		bus_d.oe  = 8'h00;
		if (preloadBusy || preloadStart) begin
			// only the clock and data-to-rom lines are driven; bit two is an input
			bus_d.out[brps_pkg::SR_CLK_BIT]  = srClock;      // [R15]
			bus_d.out[brps_pkg::SR_DOUT_BIT] = srDataOut;    // [R15]
			bus_d.oe[brps_pkg::SR_CLK_BIT]   = 1'b1;
			bus_d.oe[brps_pkg::SR_DOUT_BIT]  = 1'b1;
		end else if (pst_d == P_ADDR) begin
			bus_d.out = addrByte(cur_d.addr, byteCnt_d);     // [R1] [R2]
			bus_d.oe  = 8'hff;
		end else if (cur_d.write && (inAccess || pst_d == P_HOLD)) begin
			bus_d.out = cur_d.wdata;                          // [R12]
			bus_d.oe  = 8'hff;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			latchN_q <= 1'b1;
			selN_q   <= 1'b1;
			rdN_q    <= 1'b1;
			wrN_q    <= 1'b1;
			bus_q    <= '0;
		end else begin
			latchN_q <= !(pst_d == P_ADDR);                                  // [R1] [R3]
			selN_q   <= !(pst_d == P_LEAD || pst_d == P_STROBE);             // [R5] [R6]
			rdN_q    <= !(pst_d == P_STROBE && !cur_d.write);                // [R9] [R11]
			wrN_q    <= !(pst_d == P_STROBE && cur_d.write);                 // [R13]
			bus_q    <= bus_d;
		end
	end

	assign rom_addr_latch_enable_n = latchN_q;
	assign rom_select_n_out        = selN_q;
	assign rom_select_n_oe         = !cfg.multiDev;             // [R7] [R17]
	assign rom_read_strobe_n       = rdN_q;
	assign rom_write_strobe_n      = wrN_q;
	assign rom_shared_bus          = bus_q;

endmodule : brps_sequencer
`default_nettype wire

// ==== brps_sequencer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// pin timing checks beside the sequencer
module brps_sequencer_asserts (
	input wire logic                clk_sys,
	input wire logic                rst_b,
	input wire brps_pkg::brps_cfg_s cfg,
	input wire logic                rspValid,
	input wire brps_pkg::brps_bus_s rom_shared_bus,
	input wire logic                rom_addr_latch_enable_n,
	input wire logic                rom_latch_clock_out,
	input wire logic                rom_select_n_out,
	input wire logic                rom_select_n_oe,
	input wire logic                rom_device_ready_n,
	input wire logic                rom_read_strobe_n,
	input wire logic                rom_write_strobe_n,
	input wire logic                serial_rom_select
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// ==========
	// assertions; the first edge after reset is skipped where $past sees reset
	AST_LATCH_CLK_HALF: assert property ($past(rst_b) |-> rom_latch_clock_out != $past(rom_latch_clock_out))
		else $error("latch clock not toggling every clock");
	AST_MODE_PIN: assert property (rom_select_n_oe == !cfg.multiDev)
		else $error("select pin drive does not follow mode");
	AST_LATCH_HELD: assert property ($fell(rom_addr_latch_enable_n) |->
		(rom_shared_bus.oe == 8'hff && !rom_addr_latch_enable_n)[*5])
		else $error("latch enable released before all address bytes");
	AST_SELECT_AFTER_ADDR: assert property ($fell(rom_select_n_out) |-> rom_addr_latch_enable_n)
		else $error("select asserted during address phase");
	AST_READ_IN_SELECT: assert property (!cfg.multiDev && !rom_read_strobe_n |-> !rom_select_n_out)
		else $error("read strobe outside select");
	AST_WRITE_IN_SELECT: assert property (!cfg.multiDev && !rom_write_strobe_n |-> !rom_select_n_out)
		else $error("write strobe outside select");
	AST_READ_BUS_FREE: assert property (!rom_read_strobe_n |-> rom_shared_bus.oe == 8'h00)
		else $error("bus driven during read strobe");
	AST_WRITE_DATA_HELD: assert property (!rom_write_strobe_n |=>
		rom_shared_bus.oe == 8'hff && $stable(rom_shared_bus.out))
		else $error("write data moved before strobe rise");
	AST_READY_STRETCH: assert property ((cfg.multiDev && !rom_read_strobe_n && !rom_device_ready_n)[*3]
		|=> !rom_read_strobe_n)
		else $error("read strobe ended while ready low");
	AST_SERIAL_PINS: assert property (serial_rom_select |-> rom_shared_bus.oe[2:0] == 3'h3)
		else $error("serial pins driven wrongly");
	AST_RSP_PULSE: assert property (rspValid |=> !rspValid)
		else $error("response longer than one cycle");
	// ==========
	// main scenarios reached
	COV_READ: cover property ($rose(rom_read_strobe_n));
	COV_WRITE: cover property ($rose(rom_write_strobe_n));
	COV_SERIAL: cover property ($rose(serial_rom_select));
endmodule : brps_sequencer_asserts
`default_nettype wire

// ==== brps_rom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// parallel rom with address latches, ready pin and serial rom
module brps_rom_model (
	input  wire logic                clk_sys,
	input  wire logic                keyGood,   // 0: rom answers a wrong key
	input  wire logic [3:0]          stall,     // ready-low clocks per strobe
	input  wire brps_pkg::brps_bus_s bus,
	input  wire logic                latchN,
	input  wire logic                latchClk,
	input  wire logic                rdN,
	input  wire logic                wrN,
	input  wire logic                serSel,
	output logic [7:0]               busPin,    // resolved shared bus level
	output logic                     readyN,
	output logic [23:0]              addr,      // latched address
	output logic [7:0]               lastWrite,
	output int                       serRises   // serial clock rises this frame
);
	logic [7:0] lastPin = 8'h00;
	logic [7:0] rdByte;
	logic [3:0] stallCnt;
	logic       serBit, latchClkQ, serClkQ, wrQ, selQ;
	// contents: a fixed mix of the address bytes
	assign rdByte = addr[7:0] ^ addr[15:8] ^ addr[23:16] ^ 8'h5a;
	// key bits on rises 11 and 12, then the byte msb first
	always_comb begin
		if (serRises == 11) serBit = keyGood;
		else if (serRises > 11 && serRises < 21) serBit = (serRises == 12) ? 1'b0 : 8'ha5 >> (20 - serRises);
		else serBit = 1'b1;
	end
	// released lines invert so a stale value never passes; bit 2 has a pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (bus.oe[i]) busPin[i] = bus.out[i];
			else if (!rdN && latchN) busPin[i] = rdByte[i]; // chip enabled only with latch high
			else if (i == 2) busPin[i] = serSel ? serBit : 1'b1;
			else busPin[i] = ~lastPin[i];
		end
	end
	assign readyN = !((!rdN || !wrN) && stallCnt != 4'h0);
	// latches, write capture, stall count and serial clock count
	always @(posedge clk_sys) begin
		lastPin <= busPin;
		latchClkQ <= latchClk;
		serClkQ <= bus.out[0];
		wrQ <= wrN;
		selQ <= serSel;
		if (latchClk && !latchClkQ && !latchN) addr <= {addr[15:0], busPin};
		if (wrN && !wrQ) lastWrite <= busPin;
		if (rdN && wrN) stallCnt <= stall;
		else if (stallCnt != 4'h0) stallCnt <= stallCnt - 4'h1;
		if (serSel && !selQ) serRises <= 0;
		else if (serSel && bus.out[0] && !serClkQ) serRises <= serRises + 1;
	end
endmodule : brps_rom_model
`default_nettype wire

// ==== brps_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module brps_sequencer_tb;
	// ==========
	// pins and records
	brps_pkg::brps_cfg_s cfg;
	brps_pkg::brps_req_s req;
	brps_pkg::brps_bus_s bus;
	logic                clk_sys, rst_b, reqValid, reqReady, rspValid, keyGood;
	logic                preloadStart, preloadBusy, preloadDone, preloadKeyOk;
	logic [7:0]          rspData, preloadByte, busPin, mWrite;
	logic                latchN, latchClk, selOut, selOe, modelReady, rdN, wrN, serSel;
	logic [3:0]          stall;
	logic [23:0]         mAddr;
	int                  serRises, fails, n_checks, cyc, tSel, tRd, leadRd, leadWr, rdLen, selLen;
	wire logic           readyPin = selOe ? selOut : modelReady; // one pin, two uses
	brps_sequencer dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cfg(cfg), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .preloadStart(preloadStart),
		.preloadBusy(preloadBusy), .preloadDone(preloadDone), .preloadKeyOk(preloadKeyOk),
		.preloadByte(preloadByte), .rom_shared_bus_in(busPin), .rom_shared_bus(bus),
		.rom_addr_latch_enable_n(latchN), .rom_latch_clock_out(latchClk), .rom_select_n_out(selOut),
		.rom_select_n_oe(selOe), .rom_device_ready_n(readyPin), .rom_read_strobe_n(rdN),
		.rom_write_strobe_n(wrN), .serial_rom_select(serSel));
	brps_rom_model rom_u (.clk_sys(clk_sys), .keyGood(keyGood), .stall(stall), .bus(bus), .latchN(latchN),
		.latchClk(latchClk), .rdN(rdN), .wrN(wrN), .serSel(serSel), .busPin(busPin), .readyN(modelReady),
		.addr(mAddr), .lastWrite(mWrite), .serRises(serRises));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// edge times of select and strobes, in clocks
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if ($fell(selOut)) tSel <= cyc;
		if ($rose(selOut)) selLen <= cyc - tSel;
		if ($fell(rdN)) tRd <= cyc;
		if ($fell(rdN)) leadRd <= cyc - tSel;
		if ($fell(wrN)) leadWr <= cyc - tSel;
		if ($rose(rdN)) rdLen <= cyc - tRd;
	end
	// ==========
	// shared tasks
	function automatic logic [7:0] romByte(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
	endfunction : romByte
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic setCfg(input logic m, input logic [3:0] a, input logic [3:0] r, input logic [3:0] s);
		@(negedge clk_sys);
		cfg = '{multiDev: m, accessTime: a, readMask: r, writeMask: s};
	endtask : setCfg
	// request held until taken, then wait for the response pulse
	task automatic access(input logic w, input logic [23:0] a, input logic [7:0] d);
		int k;
		@(negedge clk_sys);
		reqValid = 1'b1;
		req = '{write: w, addr: a, wdata: d};
		// ready is looked at mid-cycle, so the accepting edge is the next rising one
		k = 0;
		while (reqReady !== 1'b1 && ++k < 100) @(negedge clk_sys);
		@(negedge clk_sys);
		reqValid = 1'b0;
		k = 0;
		do begin @(posedge clk_sys); #1; end while (rspValid !== 1'b1 && ++k < 500);
		check("rspValid", 1, rspValid);
	endtask : access
	// ==========
	// scenarios
	task automatic t_rw;
		setCfg(1'b0, 4'h0, 4'h0, 4'h0);
		access(1'b0, 24'h123456, 8'h00);
		check("readByte", romByte(24'h123456), rspData);
		check("readAddr", 24'h123456, mAddr);
		access(1'b0, 24'hfedcba, 8'h00);
		check("readAddr2", 24'hfedcba, mAddr);
		access(1'b1, 24'h00ff01, 8'h3c);
		check("writeByte", 8'h3c, mWrite);
		$display("test read write done");
	endtask : t_rw
	// lead and length grow by two clocks per setting step
	task automatic t_timing;
		int ld[3], lw[3], rl[3], sl[3];
		logic [3:0] a[3] = '{4'h0, 4'h0, 4'h3};
		logic [3:0] m[3] = '{4'h0, 4'h3, 4'h0};
		for (int i = 0; i < 3; i++) begin
			setCfg(1'b0, a[i], m[i], m[i]);
			access(1'b0, 24'h000100, 8'h00);
			ld[i] = leadRd;
			rl[i] = rdLen;
			sl[i] = selLen;
			access(1'b1, 24'h000100, 8'h77);
			lw[i] = leadWr;
		end
		check("readLead", 6, ld[1] - ld[0]);
		check("writeLead", 6, lw[1] - lw[0]);
		check("selectLen", 6, sl[2] - sl[0]);
		check("strobeLen", 6, rl[2] - rl[0]);
		$display("test timing done");
	endtask : t_timing
	task automatic t_stall;
		int base;
		setCfg(1'b1, 4'h1, 4'h0, 4'h0);
		access(1'b0, 24'h0a0b0c, 8'h00);
		base = rdLen;
		check("selectOff", 0, selOe);
		stall = 4'h8;
		access(1'b0, 24'h0a0b0c, 8'h00);
		check("stretched", 1, rdLen > base + 2);
		check("slowRead", romByte(24'h0a0b0c), rspData);
		stall = 4'h0;
		$display("test ready done");
	endtask : t_stall
	task automatic t_preload(input logic good);
		int k;
		@(negedge clk_sys);
		keyGood = good;
		preloadStart = 1'b1;
		@(negedge clk_sys);
		preloadStart = 1'b0;
		check("serialSel", 1, serSel);
		check("refused", 0, reqReady);
		k = 0;
		do begin @(posedge clk_sys); #1; end while (preloadDone !== 1'b1 && ++k < 1000);
		check("preloadDone", 1, preloadDone);
		check("keyOk", good, preloadKeyOk);
		check("preloadByte", good ? 8'ha5 : 8'h00, preloadByte);
		// eleven command rises; the first key bit is read before a twelfth rise
		if (!good) check("bitsRead", 11, serRises);
		$display("test preload done");
	endtask : t_preload
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	// ==========
	// main sequence and watchdog (about forty times the expected run)
	initial begin
		rst_b = 1'b0;
		reqValid = 1'b0;
		preloadStart = 1'b0;
		req = '0;
		keyGood = 1'b1;
		stall = 4'h0;
		cfg = '0;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		check("resetPins", 32'hf, {rdN, wrN, latchN, selOut});
		check("resetBus", 0, bus.oe);
		rst_b = 1'b1;
		t_rw();
		t_timing();
		t_stall();
		t_preload(1'b1);
		t_preload(1'b0);
		test_done();
	end
	initial begin
		#100000;
		fails++;
		test_done();
	end
endmodule : brps_sequencer_tb
bind brps_sequencer brps_sequencer_asserts chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .cfg(cfg),
	.rspValid(rspValid), .rom_shared_bus(rom_shared_bus), .rom_addr_latch_enable_n(rom_addr_latch_enable_n),
	.rom_latch_clock_out(rom_latch_clock_out), .rom_select_n_out(rom_select_n_out),
	.rom_select_n_oe(rom_select_n_oe), .rom_device_ready_n(rom_device_ready_n),
	.rom_read_strobe_n(rom_read_strobe_n), .rom_write_strobe_n(rom_write_strobe_n),
	.serial_rom_select(serial_rom_select));
`default_nettype wire
